/* hdl/hpagc_pkg.sv */
// Package: headphone amp gain control map, fields and reset values
package hpagc_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_LEFT_CTRL = 8'hD0;
  localparam logic [7:0] OFS_LEFT_GAIN = 8'hD1;
  localparam logic [7:0] OFS_RIGHT_CTRL = 8'hD2;
  localparam logic [7:0] OFS_RIGHT_GAIN = 8'hD3;
  localparam logic [7:0] OFS_OUT_CFG = 8'hD5;
  localparam logic [7:0] OFS_RAIL_KEY = 8'hD7;
  // ==========================================================
  // Control, output config and gain register fields
  localparam int BIT_POWER = 7;
  localparam int BIT_SILENCE = 6;
  localparam int BIT_SLEW = 5;
  localparam int BIT_ZERO_CROSS = 4;
  localparam int BIT_DRIVE = 3;
  localparam int BIT_FORCE_LOW = 2;
  localparam int BIT_SINGLE_RAIL = 4;
  localparam int BIT_BALANCED = 0;
  localparam int GAIN_MSB = 5;
  // ==========================================================
  // Reset values and codes
  localparam logic RST_POWER = 1'b0;
  localparam logic RST_SILENCE = 1'b1;
  localparam logic RST_SLEW = 1'b0;
  localparam logic RST_ZERO_CROSS = 1'b0;
  localparam logic RST_DRIVE = 1'b0;
  localparam logic RST_FORCE_LOW = 1'b0;
  localparam logic RST_BALANCED = 1'b0;
  localparam logic RST_SINGLE_RAIL = 1'b0;
  localparam logic [5:0] RST_GAIN = 6'h3B;
  localparam logic [5:0] GAIN_LOWEST = 6'h15;
  localparam logic [7:0] RAIL_KEY = 8'hC3;
  localparam logic [7:0] RST_RAIL_KEY = 8'hC3;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // ==========================================================
  // Gain update states, one-hot
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_WAIT_ZERO = 3'b010,
    ST_SLEW = 3'b100
  } hpagc_state_type;
endpackage

/* hdl/hpagc_gain_track.sv */
// Per-channel applied gain tracking: instant, zero-cross or slew
`timescale 1ns/10ps
module hpagc_gain_track import hpagc_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic slew_en_i,
  input wire logic zero_cross_en_i,
  input wire logic [5:0] target_gain_i,
  input wire logic sample_tick_i,
  input wire logic zero_cross_i,
  output logic [5:0] applied_gain_o
);
  // ==========================================================
  // Step helper
  function automatic logic [5:0] hpagc_step(input logic [5:0] cur,
                                            input logic [5:0] tgt);
    hpagc_step = (cur < tgt) ? cur + 6'h1 : cur - 6'h1;
  endfunction

  hpagc_state_type state;
  hpagc_state_type next_state;
  logic [5:0] applied;
  logic differs;

  assign differs = (applied != target_gain_i);
  assign applied_gain_o = applied;

  // ==========================================================
  // Next state; slew always outranks zero-cross
  always_comb begin
    next_state = state;
    case (state)
      ST_HOLD: begin
        if (differs && slew_en_i) begin
          next_state = ST_SLEW;
        end else if (differs && zero_cross_en_i) begin
          next_state = ST_WAIT_ZERO;
        end
      end
      ST_WAIT_ZERO: begin
        if (slew_en_i) begin
          next_state = ST_SLEW;
        end else if (!differs || !zero_cross_en_i || zero_cross_i) begin
          next_state = ST_HOLD;
        end
      end
      ST_SLEW: begin
        if (!slew_en_i || !differs) begin
          next_state = ST_HOLD;
        end
      end
      default: next_state = ST_HOLD;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Applied gain; one code per sample while slewing
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      applied <= RST_GAIN;
    end else if (state == ST_HOLD && differs && !slew_en_i && !zero_cross_en_i) begin
      applied <= target_gain_i;
    end else if (state == ST_WAIT_ZERO && !slew_en_i && differs &&
                 (zero_cross_i || !zero_cross_en_i)) begin
      applied <= target_gain_i;
    end else if (state == ST_SLEW && slew_en_i && differs && sample_tick_i) begin
      applied <= hpagc_step(applied, target_gain_i);
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_INSTANT: assert property (
    (state == ST_HOLD && !slew_en_i && !zero_cross_en_i && differs)
    |=> applied == $past(target_gain_i))
    else $error("instant gain not applied");
  AST_ZC_WAIT: assert property (
    (state == ST_WAIT_ZERO && zero_cross_en_i && !slew_en_i && !zero_cross_i)
    |=> $stable(applied))
    else $error("gain moved before zero crossing");
  AST_SLEW_STEP: assert property (
    (state == ST_SLEW && slew_en_i && differs && sample_tick_i)
    |=> (applied == $past(applied) + 6'h1) || (applied == $past(applied) - 6'h1))
    else $error("slew step not one code");
  AST_SLEW_IDLE: assert property (
    (state == ST_SLEW && !sample_tick_i) |=> $stable(applied))
    else $error("slew moved without sample tick");
  AST_OVERRIDE: assert property (
    (state != ST_SLEW && slew_en_i && zero_cross_en_i && differs)
    |=> state == ST_SLEW)
    else $error("slew did not override zero cross");
endmodule // hpagc_gain_track

/* hdl/hpagc_top.sv */
// Headphone amplifier gain control: registers, unlock and channels
//
// Functional notes
// - Control bit 7 powers each amplifier, reset off.
// - Control bit 6 mutes each amplifier, reset muted.
// - Control bit 5 makes gain changes step from old to new gain.
// - Control bit 4 applies a new gain only at a data zero crossing.
// - With bits 5 and 4 both set, stepping wins and zero-cross is ignored.
// - With bits 5 and 4 clear, a gain write applies at once.
// - Control bit 3 drives the output when set, else high impedance.
// - Control bit 2 forces the gain to its lowest code.
// - Gain is a six-bit code in 1.5 dB steps, 0x15 lowest valid, 0x3B 0 dB.
// - Single-rail bit 4 is writable only after the key 0xC3 is written.
`timescale 1ns/10ps
module hpagc_top import hpagc_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic sample_tick_i,
  input wire logic left_zero_cross_i,
  input wire logic right_zero_cross_i,
  output logic [7:0] reg_rdata_o,
  output logic left_amp_power_o,
  output logic left_amp_silence_o,
  output logic left_output_drive_o,
  output logic [5:0] left_gain_o,
  output logic right_amp_power_o,
  output logic right_amp_silence_o,
  output logic right_output_drive_o,
  output logic [5:0] right_gain_o,
  output logic balanced_output_select_o,
  output logic single_rail_select_o
);
  // ==========================================================
  // Helpers
  function automatic logic [7:0] hpagc_ctrl_byte(
    input logic pwr, input logic sil, input logic slw,
    input logic zc, input logic drv, input logic low);
    hpagc_ctrl_byte = {pwr, sil, slw, zc, drv, low, 2'b00};
  endfunction

  function automatic logic [5:0] hpagc_eff_gain(input logic low,
                                                input logic [5:0] g);
    hpagc_eff_gain = low ? GAIN_LOWEST : g;
  endfunction

  // ==========================================================
  // Reset release through two flops
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ==========================================================
  // Register state
  logic left_amp_power;
  logic left_amp_silence;
  logic left_gain_slew;
  logic left_gain_zero_cross;
  logic left_output_drive;
  logic left_force_lowest_gain;
  logic [5:0] left_gain_code;
  logic right_amp_power;
  logic right_amp_silence;
  logic right_gain_slew;
  logic right_gain_zero_cross;
  logic right_output_drive;
  logic right_force_lowest_gain;
  logic [5:0] right_gain_code;
  logic balanced_output_select;
  logic single_rail_select;
  logic [7:0] rail_setting_key;
  logic rail_unlocked;
  logic [5:0] left_applied;
  logic [5:0] right_applied;

  logic wr_lc;
  logic wr_lg;
  logic wr_rc;
  logic wr_rg;
  logic wr_cfg;
  logic wr_key;

  assign wr_lc = reg_wr_i && (reg_addr_i == OFS_LEFT_CTRL);
  assign wr_lg = reg_wr_i && (reg_addr_i == OFS_LEFT_GAIN);
  assign wr_rc = reg_wr_i && (reg_addr_i == OFS_RIGHT_CTRL);
  assign wr_rg = reg_wr_i && (reg_addr_i == OFS_RIGHT_GAIN);
  assign wr_cfg = reg_wr_i && (reg_addr_i == OFS_OUT_CFG);
  assign wr_key = reg_wr_i && (reg_addr_i == OFS_RAIL_KEY);

  // ==========================================================
  // Left control and gain
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      left_amp_power <= RST_POWER;
      left_amp_silence <= RST_SILENCE;
      left_gain_slew <= RST_SLEW;
      left_gain_zero_cross <= RST_ZERO_CROSS;
      left_output_drive <= RST_DRIVE;
      left_force_lowest_gain <= RST_FORCE_LOW;
    end else if (wr_lc) begin
      left_amp_power <= reg_wdata_i[BIT_POWER];
      left_amp_silence <= reg_wdata_i[BIT_SILENCE];
      left_gain_slew <= reg_wdata_i[BIT_SLEW];
      left_gain_zero_cross <= reg_wdata_i[BIT_ZERO_CROSS];
      left_output_drive <= reg_wdata_i[BIT_DRIVE];
      left_force_lowest_gain <= reg_wdata_i[BIT_FORCE_LOW];
    end
  end

  // Gain code stored as written; reserved codes are not trapped
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      left_gain_code <= RST_GAIN;
    end else if (wr_lg) begin
      left_gain_code <= reg_wdata_i[GAIN_MSB:0];
    end
  end

  // ==========================================================
  // Right control and gain, a mirror of the left
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      right_amp_power <= RST_POWER;
      right_amp_silence <= RST_SILENCE;
      right_gain_slew <= RST_SLEW;
      right_gain_zero_cross <= RST_ZERO_CROSS;
      right_output_drive <= RST_DRIVE;
      right_force_lowest_gain <= RST_FORCE_LOW;
    end else if (wr_rc) begin
      right_amp_power <= reg_wdata_i[BIT_POWER];
      right_amp_silence <= reg_wdata_i[BIT_SILENCE];
      right_gain_slew <= reg_wdata_i[BIT_SLEW];
      right_gain_zero_cross <= reg_wdata_i[BIT_ZERO_CROSS];
      right_output_drive <= reg_wdata_i[BIT_DRIVE];
      right_force_lowest_gain <= reg_wdata_i[BIT_FORCE_LOW];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      right_gain_code <= RST_GAIN;
    end else if (wr_rg) begin
      right_gain_code <= reg_wdata_i[GAIN_MSB:0];
    end
  end

  // ==========================================================
  // Output config; single-rail guarded by the key
  // Balanced bit is stored as written; software must keep it set
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      balanced_output_select <= RST_BALANCED;
      single_rail_select <= RST_SINGLE_RAIL;
    end else if (wr_cfg) begin
      balanced_output_select <= reg_wdata_i[BIT_BALANCED];
      if (rail_unlocked) begin
        single_rail_select <= reg_wdata_i[BIT_SINGLE_RAIL];
      end
    end
  end

  // Key opens one config write; any config write closes it again
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rail_setting_key <= RST_RAIL_KEY;
      rail_unlocked <= 1'b0;
    end else if (wr_key) begin
      rail_setting_key <= reg_wdata_i;
      rail_unlocked <= (reg_wdata_i == RAIL_KEY);
    end else if (wr_cfg) begin
      rail_unlocked <= 1'b0;
    end
  end

  // ==========================================================
  // Read port, answered one clock after the strobe
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= RD_UNMAPPED;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_LEFT_CTRL: reg_rdata_o <= hpagc_ctrl_byte(left_amp_power,
          left_amp_silence, left_gain_slew, left_gain_zero_cross,
          left_output_drive, left_force_lowest_gain);
        OFS_LEFT_GAIN: reg_rdata_o <= {2'b00, left_gain_code};
        OFS_RIGHT_CTRL: reg_rdata_o <= hpagc_ctrl_byte(right_amp_power,
          right_amp_silence, right_gain_slew, right_gain_zero_cross,
          right_output_drive, right_force_lowest_gain);
        OFS_RIGHT_GAIN: reg_rdata_o <= {2'b00, right_gain_code};
        OFS_OUT_CFG: reg_rdata_o <= {3'b000, single_rail_select, 3'b000,
                                     balanced_output_select};
        OFS_RAIL_KEY: reg_rdata_o <= rail_setting_key;
        default: reg_rdata_o <= RD_UNMAPPED;
      endcase
    end
  end

  // ==========================================================
  // Channel gain trackers
  hpagc_gain_track u_left (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_n),
    .slew_en_i(left_gain_slew),
    .zero_cross_en_i(left_gain_zero_cross),
    .target_gain_i(left_gain_code),
    .sample_tick_i(sample_tick_i),
    .zero_cross_i(left_zero_cross_i),
    .applied_gain_o(left_applied)
  );

  hpagc_gain_track u_right (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_n),
    .slew_en_i(right_gain_slew),
    .zero_cross_en_i(right_gain_zero_cross),
    .target_gain_i(right_gain_code),
    .sample_tick_i(sample_tick_i),
    .zero_cross_i(right_zero_cross_i),
    .applied_gain_o(right_applied)
  );

  // ==========================================================
  // Gain outputs; override applied after tracking so it is instant
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      left_gain_o <= RST_GAIN;
      right_gain_o <= RST_GAIN;
    end else begin
      left_gain_o <= hpagc_eff_gain(left_force_lowest_gain, left_applied);
      right_gain_o <= hpagc_eff_gain(right_force_lowest_gain, right_applied);
    end
  end

  // Level outputs straight from control flops
  assign left_amp_power_o = left_amp_power;
  assign left_amp_silence_o = left_amp_silence;
  assign left_output_drive_o = left_output_drive;
  assign right_amp_power_o = right_amp_power;
  assign right_amp_silence_o = right_amp_silence;
  assign right_output_drive_o = right_output_drive;
  assign balanced_output_select_o = balanced_output_select;
  assign single_rail_select_o = single_rail_select;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  sequence key_write;
    wr_key && (reg_wdata_i == RAIL_KEY);
  endsequence
  sequence cfg_write;
    wr_cfg && !wr_key;
  endsequence

  AST_POWER: assert property (
    wr_lc |=> left_amp_power_o == $past(reg_wdata_i[BIT_POWER]))
    else $error("left power not taken from write");
  AST_SILENCE: assert property (
    wr_rc |=> right_amp_silence_o == $past(reg_wdata_i[BIT_SILENCE]))
    else $error("right mute not taken from write");
  AST_DRIVE: assert property (
    !wr_lc ##1 !wr_lc |-> $stable(left_output_drive_o))
    else $error("drive changed without write");
  AST_LOWEST: assert property (
    left_force_lowest_gain |=> left_gain_o == GAIN_LOWEST)
    else $error("forced lowest gain not applied");
  AST_NORMAL: assert property (
    !right_force_lowest_gain |=> right_gain_o == $past(right_applied))
    else $error("normal gain not passed through");
  AST_LOCKED: assert property (
    (wr_cfg && !rail_unlocked) |=> $stable(single_rail_select_o))
    else $error("single rail changed while locked");
  // Key, two idle bus cycles, then the config write: the armed path as software drives it
  AST_UNLOCK: assert property (
    key_write ##1 (!reg_wr_i)[*2] ##1 cfg_write
    |=> single_rail_select_o == $past(reg_wdata_i[BIT_SINGLE_RAIL]))
    else $error("single rail not written after key");
  AST_RELOCK: assert property (
    cfg_write |=> !rail_unlocked)
    else $error("unlock not consumed by config write");
  AST_MIRROR: assert property (
    wr_rc |=> right_gain_slew == $past(reg_wdata_i[BIT_SLEW]) &&
              right_gain_zero_cross == $past(reg_wdata_i[BIT_ZERO_CROSS]))
    else $error("right control not taken from write");
endmodule // hpagc_top

/* test/test_headphone_amp_gain_control.sv */
// Testbench: register port, gain tracking and rail unlock of the amp control
`timescale 1ns/10ps
module test_headphone_amp_gain_control import hpagc_pkg::*; ;
  // ==========================================================
  // Stimulus and observed signals
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic sample_tick_i = 1'b0;
  logic left_zero_cross_i = 1'b0;
  logic right_zero_cross_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic left_amp_power_o, left_amp_silence_o, left_output_drive_o;
  logic right_amp_power_o, right_amp_silence_o, right_output_drive_o;
  logic [5:0] left_gain_o, right_gain_o;
  logic balanced_output_select_o, single_rail_select_o;
  int num_errors = 0;
  int n_checks = 0;
  logic [7:0] ca, ga, other;
  logic [7:0] map_addr [8] = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6, 8'hD7};
  logic [7:0] map_rst [8] = '{8'h40, 8'h3B, 8'h40, 8'h3B, 8'h00, 8'h00, 8'h00, 8'hC3};

  hpagc_top i_hpagc_top (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .sample_tick_i(sample_tick_i),
    .left_zero_cross_i(left_zero_cross_i), .right_zero_cross_i(right_zero_cross_i),
    .reg_rdata_o(reg_rdata_o), .left_amp_power_o(left_amp_power_o),
    .left_amp_silence_o(left_amp_silence_o), .left_output_drive_o(left_output_drive_o),
    .left_gain_o(left_gain_o), .right_amp_power_o(right_amp_power_o),
    .right_amp_silence_o(right_amp_silence_o), .right_output_drive_o(right_output_drive_o),
    .right_gain_o(right_gain_o), .balanced_output_select_o(balanced_output_select_o),
    .single_rail_select_o(single_rail_select_o)
  );

  // 50 MHz clock
  always #10 sys_clk_i = ~sys_clk_i;

  // ==========================================================
  // Helpers
  // Flags packed as power, silence, drive so one compare covers all three
  function automatic logic [7:0] flags_of(input int ch);
    if (ch == 1) return {5'b0, right_amp_power_o, right_amp_silence_o, right_output_drive_o};
    return {5'b0, left_amp_power_o, left_amp_silence_o, left_output_drive_o};
  endfunction

  function automatic logic [7:0] gain_of(input int ch);
    return (ch == 1) ? {2'b00, right_gain_o} : {2'b00, left_gain_o};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask

  // Write taken at the second edge; one spare edge lets outputs settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
  endtask

  // Read data is registered and holds, so sampling one edge late is safe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk(reg_rdata_o, exp);
  endtask

  // One sample period pulse, then two edges for applied gain and output
  task automatic tick();
    @(posedge sys_clk_i);
    sample_tick_i <= 1'b1;
    @(posedge sys_clk_i);
    sample_tick_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic zc_pulse(input int ch);
    @(posedge sys_clk_i);
    if (ch == 1) right_zero_cross_i <= 1'b1;
    else left_zero_cross_i <= 1'b1;
    @(posedge sys_clk_i);
    right_zero_cross_i <= 1'b0;
    left_zero_cross_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask

  // Bounded wait; running out counts a mismatch and ends the run
  task automatic wait_gain(input int ch, input logic [7:0] exp);
    for (int i = 0; i < 8; i++) begin
      if (gain_of(ch) === exp) break;
      @(posedge sys_clk_i);
      #1;
    end
    chk(gain_of(ch), exp);
    if (gain_of(ch) !== exp) final_report();
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    // Reset state at the pins and in the map, unmapped places read zero
    chk(flags_of(0), 8'h02);
    chk(flags_of(1), 8'h02);
    chk(gain_of(0), {2'b00, RST_GAIN});
    chk({6'b0, balanced_output_select_o, single_rail_select_o}, 8'h00);
    for (int k = 0; k < 8; k++) begin
      rd_chk(map_addr[k], map_rst[k]);
    end
    // Both channels walk the same sequence; the idle one must not move
    for (int ch = 0; ch < 2; ch++) begin
      ca = OFS_LEFT_CTRL + 8'(2 * ch);
      ga = ca + 8'h01;
      other = gain_of(1 - ch);
      wr(ca, 8'h88);
      chk(flags_of(ch), 8'h05);
      rd_chk(ca, 8'h88);
      wr(ca, 8'h43);
      chk(flags_of(ch), 8'h02);
      rd_chk(ca, 8'h40);
      // Instant updates to the top code 0x3F, then down to 0x20
      wr(ca, 8'h00);
      wr(ga, 8'hFF);
      wait_gain(ch, 8'h3F);
      wr(ga, 8'hE0);
      wait_gain(ch, 8'h20);
      rd_chk(ga, 8'h20);
      // Forced lowest code overrides, then normal gain returns
      wr(ca, 8'h04);
      wait_gain(ch, {2'b00, GAIN_LOWEST});
      wr(ca, 8'h00);
      wait_gain(ch, 8'h20);
      // Zero-cross wait: the other channel's crossing must not release it
      wr(ca, 8'h10);
      wr(ga, 8'h30);
      repeat (10) @(posedge sys_clk_i);
      #1;
      chk(gain_of(ch), 8'h20);
      zc_pulse(1 - ch);
      chk(gain_of(ch), 8'h20);
      zc_pulse(ch);
      wait_gain(ch, 8'h30);
      // Slew with zero-cross also set: a crossing must not jump the gain
      wr(ca, 8'h30);
      wr(ga, 8'h33);
      zc_pulse(ch);
      chk(gain_of(ch), 8'h30);
      for (int k = 1; k <= 3; k++) begin
        tick();
        chk(gain_of(ch), 8'h30 + 8'(k));
      end
      tick();
      chk(gain_of(ch), 8'h33);
      wr(ga, 8'h31);
      tick();
      chk(gain_of(ch), 8'h32);
      tick();
      chk(gain_of(ch), 8'h31);
      chk(gain_of(1 - ch), other);
    end
    // ==========================================================
    // Rail setting key: one-shot, disarmed by any other key value
    wr(OFS_RAIL_KEY, 8'h00);
    wr(OFS_OUT_CFG, 8'hFF);
    chk({6'b0, balanced_output_select_o, single_rail_select_o}, 8'h02);
    rd_chk(OFS_OUT_CFG, 8'h01);
    wr(OFS_RAIL_KEY, RAIL_KEY);
    wr(OFS_OUT_CFG, 8'h11);
    chk({6'b0, balanced_output_select_o, single_rail_select_o}, 8'h03);
    rd_chk(OFS_RAIL_KEY, RAIL_KEY);
    wr(OFS_OUT_CFG, 8'h01);
    chk({6'b0, balanced_output_select_o, single_rail_select_o}, 8'h03);
    wr(OFS_RAIL_KEY, RAIL_KEY);
    wr(OFS_OUT_CFG, 8'h01);
    chk({6'b0, balanced_output_select_o, single_rail_select_o}, 8'h02);
    wr(OFS_RAIL_KEY, RAIL_KEY);
    wr(OFS_RAIL_KEY, 8'h5A);
    wr(OFS_OUT_CFG, 8'h11);
    chk({6'b0, balanced_output_select_o, single_rail_select_o}, 8'h02);
    rd_chk(OFS_RAIL_KEY, 8'h5A);
    // Unmapped writes leave the map alone
    wr(8'hD4, 8'hFF);
    wr(8'hD6, 8'hFF);
    rd_chk(8'hD4, 8'h00);
    rd_chk(OFS_OUT_CFG, 8'h01);
    final_report();
  end
endmodule // test_headphone_amp_gain_control
